// ===== design/bscu_pkg.sv
// constants and types shared by the branch, skip and compare unit
// assumes one core clock and decoded instruction fields from the core
package bscu_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int PC_W = 16;
  localparam int OFS_W = 7;

  // ------------------------------------------------------------
  // status flag bit positions
  // ------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ------------------------------------------------------------
  // reset values and cycle costs
  // ------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [1:0] COST_ONE = 2'h1;
  localparam logic [1:0] COST_TWO = 2'h2;
  localparam logic [1:0] COST_THREE = 2'h3;
  localparam logic [PC_W-1:0] STEP_ONE = 16'h0001;
  localparam logic [PC_W-1:0] STEP_TWO = 16'h0002;
  localparam logic [PC_W-1:0] STEP_THREE = 16'h0003;

  // ------------------------------------------------------------
  // operations handled by the unit
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    compare_immediate,
    skip_reg_bit_clear,
    skip_reg_bit_set,
    skip_io_bit_clear,
    skip_io_bit_set,
    branch_status_bit_set,
    branch_status_bit_clear,
    branch_equal,
    branch_not_equal,
    branch_carry_set,
    branch_carry_clear,
    branch_same_or_higher,
    branch_lower,
    branch_minus,
    branch_plus,
    branch_signed_ge,
    branch_signed_lt,
    branch_half_carry_set,
    branch_half_carry_clear,
    branch_transfer_set,
    branch_transfer_clear,
    branch_overflow_set,
    branch_overflow_clear,
    branch_irq_enabled,
    branch_irq_disabled
  } bscu_op_t;

  typedef enum logic [0:0] {
    bscu_idle,
    bscu_wait
  } bscu_state_t;

endpackage

// ===== design/bscu_cmp.sv
// subtract-only comparator producing the arithmetic flags
// assumes operands are stable in the cycle the result is used
module bscu_cmp (
  input wire logic [7:0] lhs,
  input wire logic [7:0] rhs,
  output logic z_flag,
  output logic n_flag,
  output logic v_flag,
  output logic c_flag,
  output logic h_flag
);

  logic [7:0] diff;

  // difference is only used for flags, never stored
  always_comb begin
    diff = lhs - rhs;
    z_flag = (diff == 8'h00);
    n_flag = diff[7];
    v_flag = (lhs[7] & ~rhs[7] & ~diff[7]) | (~lhs[7] & rhs[7] & diff[7]);
    c_flag = (~lhs[7] & rhs[7]) | (rhs[7] & diff[7]) | (diff[7] & ~lhs[7]);
    h_flag = (~lhs[3] & rhs[3]) | (rhs[3] & diff[3]) | (diff[3] & ~lhs[3]);
  end

endmodule

// ===== design/bscu_top.sv
// branch, skip and compare unit: next program counter, flags, cycle cost
// assumes the core holds instruction fields stable while start is high
// Notes on behaviour
// - compare immediate subtracts constant, keeps no result, sets Z N V C H, 1 cycle
// - skip on register bit clear advances pc 2 or 3, costs 1/2/3
// - skip on register bit set advances pc 2 or 3, flags kept
// - skip on io bit clear tests io data bit, advances 2 or 3
// - skip on io bit set advances 2 or 3, flags kept
// - branch on selected status bit set: pc plus offset plus one
// - branch on selected status bit clear, otherwise fall through
// - equal and not equal branch on zero flag one and zero
// - carry set and lower branch when carry is one
// - carry clear and same or higher branch when carry is zero
// - minus and plus branch on negative flag one and zero
// - signed ge when N xor V zero, signed lt when one
// - half carry branches on half carry flag one or zero
// - transfer branches on transfer flag one or zero, flags kept
// - overflow branches on overflow flag one or zero
// - irq branches on global interrupt enable one or zero
module bscu_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire bscu_pkg::bscu_op_t op,
  input wire logic [bscu_pkg::PC_W-1:0] pc_cur,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] reg_data,
  input wire logic [7:0] io_data,
  input wire logic [7:0] imm,
  input wire logic [2:0] bit_sel,
  input wire logic [2:0] status_sel,
  input wire logic [bscu_pkg::OFS_W-1:0] offset,
  input wire logic next_two_word,
  output logic ready,
  output logic done,
  output logic taken,
  output logic [1:0] cycles,
  output logic [bscu_pkg::PC_W-1:0] pc_next,
  output logic [7:0] flags_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    bscu_pkg::bscu_state_t st;
    logic [1:0] left;
    logic [1:0] cost;
    logic done;
    logic taken;
    logic [bscu_pkg::PC_W-1:0] pc;
    logic [7:0] flags;
  } bscu_regs_t;

  bscu_regs_t r_q;
  bscu_regs_t r_d;

  logic cz;
  logic cn;
  logic cv;
  logic cc;
  logic ch;
  logic cond;
  logic is_skip;
  logic is_branch;
  logic [bscu_pkg::PC_W-1:0] ofs_ext;
  logic [1:0] cost_now;

  // ------------------------------------------------------------
  // comparator
  // ------------------------------------------------------------
  bscu_cmp u_cmp (
    .lhs(reg_data),
    .rhs(imm),
    .z_flag(cz),
    .n_flag(cn),
    .v_flag(cv),
    .c_flag(cc),
    .h_flag(ch)
  );

  // condition of each skip or branch
  always_comb begin
    is_skip = 1'b1;
    is_branch = 1'b1;
    cond = 1'b0;
    unique case (op)
      bscu_pkg::compare_immediate: begin
        is_skip = 1'b0;
        is_branch = 1'b0;
      end
      bscu_pkg::skip_reg_bit_clear: begin
        is_branch = 1'b0;
        cond = ~reg_data[bit_sel];
      end
      bscu_pkg::skip_reg_bit_set: begin
        is_branch = 1'b0;
        cond = reg_data[bit_sel];
      end
      bscu_pkg::skip_io_bit_clear: begin
        is_branch = 1'b0;
        cond = ~io_data[bit_sel];
      end
      bscu_pkg::skip_io_bit_set: begin
        is_branch = 1'b0;
        cond = io_data[bit_sel];
      end
      bscu_pkg::branch_status_bit_set: begin
        is_skip = 1'b0;
        cond = flags_in[status_sel];
      end
      bscu_pkg::branch_status_bit_clear: begin
        is_skip = 1'b0;
        cond = ~flags_in[status_sel];
      end
      bscu_pkg::branch_equal: begin
        is_skip = 1'b0;
        cond = flags_in[bscu_pkg::FLAG_Z];
      end
      bscu_pkg::branch_not_equal: begin
        is_skip = 1'b0;
        cond = ~flags_in[bscu_pkg::FLAG_Z];
      end
      bscu_pkg::branch_carry_set, bscu_pkg::branch_lower: begin
        is_skip = 1'b0;
        cond = flags_in[bscu_pkg::FLAG_C];
      end
      bscu_pkg::branch_carry_clear, bscu_pkg::branch_same_or_higher: begin
        is_skip = 1'b0;
        cond = ~flags_in[bscu_pkg::FLAG_C];
      end
      bscu_pkg::branch_minus: begin
        is_skip = 1'b0;
        cond = flags_in[bscu_pkg::FLAG_N];
      end
      bscu_pkg::branch_plus: begin
        is_skip = 1'b0;
        cond = ~flags_in[bscu_pkg::FLAG_N];
      end
      bscu_pkg::branch_signed_ge: begin
        is_skip = 1'b0;
        cond = ~(flags_in[bscu_pkg::FLAG_N] ^ flags_in[bscu_pkg::FLAG_V]);
      end
      bscu_pkg::branch_signed_lt: begin
        is_skip = 1'b0;
        cond = flags_in[bscu_pkg::FLAG_N] ^ flags_in[bscu_pkg::FLAG_V];
      end
      bscu_pkg::branch_half_carry_set: begin
        is_skip = 1'b0;
        cond = flags_in[bscu_pkg::FLAG_H];
      end
      bscu_pkg::branch_half_carry_clear: begin
        is_skip = 1'b0;
        cond = ~flags_in[bscu_pkg::FLAG_H];
      end
      bscu_pkg::branch_transfer_set: begin
        is_skip = 1'b0;
        cond = flags_in[bscu_pkg::FLAG_T];
      end
      bscu_pkg::branch_transfer_clear: begin
        is_skip = 1'b0;
        cond = ~flags_in[bscu_pkg::FLAG_T];
      end
      bscu_pkg::branch_overflow_set: begin
        is_skip = 1'b0;
        cond = flags_in[bscu_pkg::FLAG_V];
      end
      bscu_pkg::branch_overflow_clear: begin
        is_skip = 1'b0;
        cond = ~flags_in[bscu_pkg::FLAG_V];
      end
      bscu_pkg::branch_irq_enabled: begin
        is_skip = 1'b0;
        cond = flags_in[bscu_pkg::FLAG_I];
      end
      bscu_pkg::branch_irq_disabled: begin
        is_skip = 1'b0;
        cond = ~flags_in[bscu_pkg::FLAG_I];
      end
      default: begin
        is_skip = 1'b0;
        is_branch = 1'b0;
      end
    endcase
  end

  // sign extension of the branch offset
  assign ofs_ext = {{(bscu_pkg::PC_W - bscu_pkg::OFS_W){offset[bscu_pkg::OFS_W-1]}}, offset};

  // cycle cost of the presented instruction
  always_comb begin
    cost_now = bscu_pkg::COST_ONE;
    if (is_branch && cond) begin
      cost_now = bscu_pkg::COST_TWO;
    end else if (is_skip && cond) begin
      cost_now = next_two_word ? bscu_pkg::COST_THREE : bscu_pkg::COST_TWO;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    unique case (r_q.st)
      bscu_pkg::bscu_idle: begin
        if (start) begin
          r_d.cost = cost_now;
          r_d.taken = cond;
          r_d.pc = pc_cur + bscu_pkg::STEP_ONE;
          if (is_branch && cond) begin
            r_d.pc = pc_cur + ofs_ext + bscu_pkg::STEP_ONE;
          end else if (is_skip && cond) begin
            r_d.pc = pc_cur + (next_two_word ? bscu_pkg::STEP_THREE
                                             : bscu_pkg::STEP_TWO);
          end
          if (op == bscu_pkg::compare_immediate) begin
            r_d.flags = flags_in;
            r_d.flags[bscu_pkg::FLAG_Z] = cz;
            r_d.flags[bscu_pkg::FLAG_N] = cn;
            r_d.flags[bscu_pkg::FLAG_V] = cv;
            r_d.flags[bscu_pkg::FLAG_C] = cc;
            r_d.flags[bscu_pkg::FLAG_H] = ch;
          end else begin
            r_d.flags = flags_in;
          end
          if (cost_now == bscu_pkg::COST_ONE) begin
            r_d.done = 1'b1;
          end else begin
            r_d.st = bscu_pkg::bscu_wait;
            r_d.left = cost_now - bscu_pkg::COST_ONE;
          end
        end
      end
      bscu_pkg::bscu_wait: begin
        r_d.left = r_q.left - bscu_pkg::COST_ONE;
        if (r_q.left == bscu_pkg::COST_ONE) begin
          r_d.done = 1'b1;
          r_d.st = bscu_pkg::bscu_idle;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '{st: bscu_pkg::bscu_idle, left: 2'h0, cost: bscu_pkg::COST_ONE,
               done: 1'b0, taken: 1'b0, pc: bscu_pkg::PC_RST,
               flags: bscu_pkg::FLAGS_RST};
    end else begin
      r_q <= r_d;
    end
  end

  // outputs
  assign ready = (r_q.st == bscu_pkg::bscu_idle);
  assign done = r_q.done;
  assign taken = r_q.taken;
  assign cycles = r_q.cost;
  assign pc_next = r_q.pc;
  assign flags_out = r_q.flags;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_cmp_flags: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::compare_immediate) |=>
      done && flags_out[bscu_pkg::FLAG_Z] == ($past(reg_data) == $past(imm)) &&
      flags_out[bscu_pkg::FLAG_C] == ($past(reg_data) < $past(imm)))
    else $error("compare flags or timing wrong");

  chk_skip_pc: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::skip_reg_bit_set && reg_data[bit_sel]) |=>
      pc_next == $past(pc_cur) + ($past(next_two_word) ? bscu_pkg::STEP_THREE
                                                       : bscu_pkg::STEP_TWO))
    else $error("skip advance wrong");

  chk_skip_none: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::skip_reg_bit_clear && reg_data[bit_sel]) |=>
      done && pc_next == $past(pc_cur) + bscu_pkg::STEP_ONE)
    else $error("skip taken on set bit");

  chk_skip_three: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::skip_io_bit_clear && !io_data[bit_sel] &&
     next_two_word) |=> !done ##1 !done ##1 done)
    else $error("three cycle skip wrong");

  chk_io_set: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::skip_io_bit_set) |=>
      taken == $past(io_data[bit_sel]) && flags_out == $past(flags_in))
    else $error("io set skip wrong");

  chk_br_taken: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::branch_equal && flags_in[bscu_pkg::FLAG_Z]) |=>
      !done && pc_next == $past(pc_cur) + $past(ofs_ext) + bscu_pkg::STEP_ONE ##1 done)
    else $error("taken branch wrong");

  chk_br_fall: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::branch_status_bit_clear &&
     flags_in[status_sel]) |=> done && cycles == bscu_pkg::COST_ONE)
    else $error("fall through wrong");

  chk_signed_lt: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::branch_signed_lt) |=>
      taken == ($past(flags_in[bscu_pkg::FLAG_N]) ^ $past(flags_in[bscu_pkg::FLAG_V])))
    else $error("signed less than wrong");

  chk_carry_alias: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::branch_same_or_higher) |=>
      taken == !$past(flags_in[bscu_pkg::FLAG_C]))
    else $error("same or higher wrong");

  chk_irq_flags: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::branch_irq_enabled) |=>
      taken == $past(flags_in[bscu_pkg::FLAG_I]) && flags_out == $past(flags_in))
    else $error("irq branch wrong");

  chk_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !ready |=> $stable(pc_next) && $stable(flags_out) && $stable(taken) &&
      $stable(cycles))
    else $error("busy instruction disturbed");

  chk_skip_two: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::skip_reg_bit_clear && !reg_data[bit_sel] &&
     !next_two_word) |=> !done && cycles == bscu_pkg::COST_TWO ##1 done)
    else $error("two cycle skip wrong");

  chk_br_not_equal: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::branch_not_equal && flags_in[bscu_pkg::FLAG_Z]) |=>
      done && !taken && pc_next == $past(pc_cur) + bscu_pkg::STEP_ONE)
    else $error("not equal fall through wrong");

  chk_carry_lower: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::branch_lower) |=>
      taken == $past(flags_in[bscu_pkg::FLAG_C]))
    else $error("lower branch wrong");

  chk_status_set: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::branch_status_bit_set) |=>
      taken == $past(flags_in[status_sel]) && flags_out == $past(flags_in))
    else $error("status bit branch wrong");

  chk_io_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (ready && start && op == bscu_pkg::skip_io_bit_clear) |=>
      taken == !$past(io_data[bit_sel]))
    else $error("io clear skip wrong");

endmodule

// ===== test/branch_skip_compare_unit_test.sv
// self-checking bench for the branch, skip and compare unit
// assumes the design package is compiled first; no partner model, bench drives all ports
module branch_skip_compare_unit_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  bscu_pkg::bscu_op_t op = bscu_pkg::compare_immediate;
  logic [bscu_pkg::PC_W-1:0] pc_cur = 16'h0000;
  logic [7:0] flags_in = 8'h00;
  logic [7:0] reg_data = 8'h00;
  logic [7:0] io_data = 8'h00;
  logic [7:0] imm = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [2:0] status_sel = 3'h0;
  logic [bscu_pkg::OFS_W-1:0] offset = 7'h00;
  logic next_two_word = 1'b0;
  logic ready;
  logic done;
  logic taken;
  logic [1:0] cycles;
  logic [bscu_pkg::PC_W-1:0] pc_next;
  logic [7:0] flags_out;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  bscu_top u_bscu_top (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(start),
    .op(op),
    .pc_cur(pc_cur),
    .flags_in(flags_in),
    .reg_data(reg_data),
    .io_data(io_data),
    .imm(imm),
    .bit_sel(bit_sel),
    .status_sel(status_sel),
    .offset(offset),
    .next_two_word(next_two_word),
    .ready(ready),
    .done(done),
    .taken(taken),
    .cycles(cycles),
    .pc_next(pc_next),
    .flags_out(flags_out)
  );

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // hang guard, far above the roughly 1600 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  // kind 0 compare, 1 skip, 2 branch; flags are C0 Z1 N2 V3 S4 H5 T6 I7
  function automatic void model(input bscu_pkg::bscu_op_t o, input logic [7:0] f,
      input logic [7:0] rd, input logic [7:0] io, input logic [7:0] k, input logic [2:0] b,
      input logic [2:0] s, input logic [6:0] ofs, input logic [15:0] pc, input logic tw,
      output logic tk, output logic [1:0] cy, output logic [15:0] pn, output logic [7:0] fo);
    int r;
    int kind;
    logic c;
    fo = f;
    tk = 1'b0;
    kind = 2;
    c = 1'b0;
    case (o)
      bscu_pkg::compare_immediate: begin
        kind = 0;
        r = (int'(rd) - int'(k)) & 255;
        fo[0] = int'(k) > int'(rd);
        fo[1] = (r == 0);
        fo[2] = r[7];
        fo[3] = 1'(((int'(rd) ^ int'(k)) & (int'(rd) ^ r)) >> 7);
        fo[5] = int'(k & 8'h0F) > int'(rd & 8'h0F);
      end
      bscu_pkg::skip_reg_bit_clear: begin
        kind = 1;
        c = !rd[b];
      end
      bscu_pkg::skip_reg_bit_set: begin
        kind = 1;
        c = rd[b];
      end
      bscu_pkg::skip_io_bit_clear: begin
        kind = 1;
        c = !io[b];
      end
      bscu_pkg::skip_io_bit_set: begin
        kind = 1;
        c = io[b];
      end
      bscu_pkg::branch_status_bit_set: c = f[s];
      bscu_pkg::branch_status_bit_clear: c = !f[s];
      bscu_pkg::branch_equal: c = f[1];
      bscu_pkg::branch_not_equal: c = !f[1];
      bscu_pkg::branch_carry_set, bscu_pkg::branch_lower: c = f[0];
      bscu_pkg::branch_carry_clear, bscu_pkg::branch_same_or_higher: c = !f[0];
      bscu_pkg::branch_minus: c = f[2];
      bscu_pkg::branch_plus: c = !f[2];
      bscu_pkg::branch_signed_ge: c = !(f[2] ^ f[3]);
      bscu_pkg::branch_signed_lt: c = f[2] ^ f[3];
      bscu_pkg::branch_half_carry_set: c = f[5];
      bscu_pkg::branch_half_carry_clear: c = !f[5];
      bscu_pkg::branch_transfer_set: c = f[6];
      bscu_pkg::branch_transfer_clear: c = !f[6];
      bscu_pkg::branch_overflow_set: c = f[3];
      bscu_pkg::branch_overflow_clear: c = !f[3];
      bscu_pkg::branch_irq_enabled: c = f[7];
      bscu_pkg::branch_irq_disabled: c = !f[7];
      default: kind = 0;
    endcase
    pn = pc + 16'h0001;
    cy = 2'h1;
    if (kind == 1 && c) begin
      tk = 1'b1;
      pn = pc + (tw ? 16'h0003 : 16'h0002);
      cy = tw ? 2'h3 : 2'h2;
    end else if (kind == 2 && c) begin
      tk = 1'b1;
      pn = pc + {{9{ofs[6]}}, ofs} + 16'h0001;
      cy = 2'h2;
    end
  endfunction

  // ------------------------------------------------------------
  // one instruction: present, take, time the completion
  // ------------------------------------------------------------
  // poke raises start again while busy; it must be ignored
  task automatic run_op(input bscu_pkg::bscu_op_t o, input logic poke);
    logic tk;
    logic [1:0] cy;
    logic [15:0] pn;
    logic [7:0] fo;
    int n;
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    pc_cur <= 16'($urandom);
    flags_in <= 8'($urandom);
    reg_data <= 8'($urandom);
    io_data <= 8'($urandom);
    imm <= 8'($urandom);
    bit_sel <= 3'($urandom);
    status_sel <= 3'($urandom);
    offset <= 7'($urandom);
    next_two_word <= 1'($urandom);
    @(posedge clk);
    model(op, flags_in, reg_data, io_data, imm, bit_sel, status_sel, offset, pc_cur,
      next_two_word, tk, cy, pn, fo);
    start <= poke && (cy != 2'h1);
    #1;
    check("pc_next", pc_next, pn);
    check("cycles", cycles, cy);
    check("flags_out", flags_out, fo);
    check("ready", ready, cy == 2'h1);
    if (o != bscu_pkg::compare_immediate) begin
      check("taken", taken, tk);
    end
    n = 1;
    while (done !== 1'b1 && n < 4) begin
      @(posedge clk);
      start <= 1'b0;
      #1;
      n++;
    end
    check("done_delay", n, cy);
    check("pc_next_held", pc_next, pn);
    check("ready_at_done", ready, 1'b1);
    if (poke) begin
      @(posedge clk);
      #1;
      check("done_once", done, 1'b0);
    end
  endtask

  task automatic check_reset();
    check("rst_ready", ready, 1'b1);
    check("rst_done", done, 1'b0);
    check("rst_taken", taken, 1'b0);
    check("rst_cycles", cycles, 2'h1);
    check("rst_pc_next", pc_next, 16'h0000);
    check("rst_flags_out", flags_out, 8'h00);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hDC86));
    repeat (9) @(posedge clk);
    #1;
    check_reset();
    @(posedge clk);
    sys_rst <= 1'b0;
    // every operation code, unlisted ones too, with random operands and outcomes
    for (int i = 0; i < 32; i++) begin
      for (int j = 0; j < 16; j++) begin
        run_op(bscu_pkg::bscu_op_t'(i), j[0]);
      end
    end
    // second reset in mid-run, then a short burst of random operations
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    #1;
    check_reset();
    @(posedge clk);
    sys_rst <= 1'b0;
    for (int j = 0; j < 40; j++) begin
      run_op(bscu_pkg::bscu_op_t'($urandom_range(24, 0)), 1'b0);
    end
    print_verdict();
  end
endmodule
